// *** core/mpc_host.sv ***
// host controller that sets up and drives the paired pwm and phase counter
`timescale 1ns/100ps
`default_nettype none
module mpc_host (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  sw_addr,
  input  wire logic [31:0] sw_wdata,
  input  wire logic        sw_we,
  input  wire logic        sw_re,
  output logic      [31:0] sw_rdata,
  output logic      [7:0]  dev_addr,
  output logic      [15:0] dev_wdata,
  output logic             dev_we,
  input  wire logic        dev_match_a3,
  input  wire logic        dev_udf4,
  output logic             phase_input_a,
  output logic             phase_input_b
);
  ////////////////////////////////////////////////////////////////////////
  mpc_pkg::mpc_state_t st;
  mpc_pkg::mpc_job_t   job;
  mpc_pkg::mpc_job_t   rjob;
  logic [3:0]  idx;
  logic [15:0] period;
  logic [15:0] off;
  logic [15:0] tp [3];
  logic [15:0] nt [3];
  logic [2:0]  dirm;
  logic        flag_direction_select;
  logic        err;
  logic [2:0]  m_s;
  logic [2:0]  u_s;
  logic [14:0] qleft;
  logic        qdir;
  logic [1:0]  qgap;
  logic [1:0]  qph;

  function automatic logic crosses(input logic [15:0] a, input logic [15:0] b,
                                   input logic [15:0] lo, input logic [15:0] hi);
    crosses = ((a >= lo) && (a <= hi)) != ((b >= lo) && (b <= hi));
  endfunction

  // device events arrive from another timing domain
  wire ev_match = m_s[1] & ~m_s[2];
  wire ev_udf   = u_s[1] & ~u_s[2];
  wire ev_any   = ev_match | ev_udf;

  wire [15:0] cp_per = {1'b0, period[15:1]} + off - 16'h0002;
  wire [15:0] band_lo = cp_per - off + 16'h0001;
  wire [15:0] off_m1  = off - 16'h0001;

  wire [2:0] rs_bad;
  wire [2:0] cp_bad;
  wire [2:0] band_bad;
  wire [2:0] out_new;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_tp
      assign rs_bad[gi] = tp[gi] > period;
      assign cp_bad[gi] = tp[gi] < off;
      assign out_new[gi] = nt[gi] > cp_per;
      // crossing the turnaround bands corrupts a half period
      // the direction guard holds on both event kinds
      assign band_bad[gi] = (ev_match ? crosses(tp[gi], nt[gi], band_lo, cp_per)
                          : crosses(tp[gi], nt[gi], 16'h0000, off_m1))
                          | ((tp[gi] > cp_per) && !out_new[gi] && (dirm[gi] != ev_match));
    end
  endgenerate

  wire cp_ok  = (off != 16'h0000) && (cp_bad == 3'b000);
  wire rs_ok  = (rs_bad == 3'b000);
  wire upd_ok = (rjob == mpc_pkg::J_RS) ? ev_match : (ev_any && (band_bad == 3'b000));

  // software side decode
  wire wr_ctrl  = sw_we && (sw_addr == mpc_pkg::SW_CTRL);
  wire wr_per   = sw_we && (sw_addr == mpc_pkg::SW_PERIOD);
  wire wr_off   = sw_we && (sw_addr == mpc_pkg::SW_OFFSET);
  wire wr_qstep = sw_we && (sw_addr == mpc_pkg::SW_QSTEP);
  wire can_cmd  = (st == mpc_pkg::S_IDLE) || (st == mpc_pkg::S_RUN);
  wire go_rs    = wr_ctrl && can_cmd && sw_wdata[mpc_pkg::C_RS];
  wire go_cp    = wr_ctrl && can_cmd && sw_wdata[mpc_pkg::C_CP];
  wire go_ph    = wr_ctrl && can_cmd && sw_wdata[mpc_pkg::C_PH];
  wire go_stop  = wr_ctrl && can_cmd && sw_wdata[mpc_pkg::C_STOP];
  wire go_upd   = wr_ctrl && (st == mpc_pkg::S_RUN) && sw_wdata[mpc_pkg::C_UPD]
                  && ((rjob == mpc_pkg::J_RS) || (rjob == mpc_pkg::J_CP));
  wire bad_cmd  = (go_rs && !rs_ok) || (go_cp && !cp_ok);

  ////////////////////////////////////////////////////////////////////////
  // setup scripts: {last, address, data} per job and step
  function automatic logic [24:0] step(input mpc_pkg::mpc_job_t j, input logic [3:0] i,
      input logic [15:0] p, input logic [15:0] o, input logic [15:0] c,
      input logic [15:0] t0, input logic [15:0] t1, input logic [15:0] t2,
      input logic [15:0] n0, input logic [15:0] n1, input logic [15:0] n2,
      input logic f);
    step = {1'b1, mpc_pkg::D_RUN, 16'h0000};
    case (j)
      mpc_pkg::J_RS: begin
        case (i)
          4'h0: step = {1'b0, mpc_pkg::D_RUN, 16'h0000};
          4'h1: step = {1'b0, mpc_pkg::D_TCR3, mpc_pkg::CLR_PERIOD_COMPARE};
          4'h2: step = {1'b0, mpc_pkg::D_FUNC, mpc_pkg::MODE_RS | mpc_pkg::BUF_ALL};
          4'h3: step = {1'b0, mpc_pkg::D_CNT3, 16'h0000};
          4'h4: step = {1'b0, mpc_pkg::D_PERIOD_COMPARE, p};
          4'h5: step = {1'b0, mpc_pkg::D_TURN_POINT_ONE, t0};
          4'h6: step = {1'b0, mpc_pkg::D_TURN_POINT_TWO, t1};
          4'h7: step = {1'b0, mpc_pkg::D_TURN_POINT_THREE, t2};
          4'h8: step = {1'b0, mpc_pkg::D_BRB3, t0};
          4'h9: step = {1'b0, mpc_pkg::D_BRA4, t1};
          4'ha: step = {1'b0, mpc_pkg::D_BRB4, t2};
          default: step = {1'b1, mpc_pkg::D_RUN, mpc_pkg::RUN3};
        endcase
      end
      mpc_pkg::J_CP: begin
        case (i)
          4'h0: step = {1'b0, mpc_pkg::D_RUN, 16'h0000};
          4'h1: step = {1'b0, mpc_pkg::D_TCR3, mpc_pkg::CLR_NONE};
          4'h2: step = {1'b0, mpc_pkg::D_TCR4, mpc_pkg::CLR_NONE};
          4'h3: step = {1'b0, mpc_pkg::D_FUNC, mpc_pkg::MODE_CP | mpc_pkg::BUF_ALL};
          4'h4: step = {1'b0, mpc_pkg::D_CNT4, 16'h0000};
          4'h5: step = {1'b0, mpc_pkg::D_CNT3, o};
          4'h6: step = {1'b0, mpc_pkg::D_PERIOD_COMPARE, c};
          4'h7: step = {1'b0, mpc_pkg::D_TURN_POINT_ONE, t0};
          4'h8: step = {1'b0, mpc_pkg::D_TURN_POINT_TWO, t1};
          4'h9: step = {1'b0, mpc_pkg::D_TURN_POINT_THREE, t2};
          4'ha: step = {1'b0, mpc_pkg::D_BRB3, t0};
          4'hb: step = {1'b0, mpc_pkg::D_BRA4, t1};
          4'hc: step = {1'b0, mpc_pkg::D_BRB4, t2};
          default: step = {1'b1, mpc_pkg::D_RUN, mpc_pkg::RUN3 | mpc_pkg::RUN4};
        endcase
      end
      mpc_pkg::J_PH: begin
        if (i == 4'h0) begin
          step = {1'b0, mpc_pkg::D_TIMER_MODE_REG, mpc_pkg::PHASE_BIT | (f ? mpc_pkg::FLAG_DIRECTION_SELECT_BIT : 16'h0000)};
        end else begin
          step = {1'b1, mpc_pkg::D_RUN, mpc_pkg::RUN2};
        end
      end
      mpc_pkg::J_BUF: begin
        case (i)
          4'h0: step = {1'b0, mpc_pkg::D_BRB3, n0};
          4'h1: step = {1'b0, mpc_pkg::D_BRA4, n1};
          default: step = {1'b1, mpc_pkg::D_BRB4, n2};
        endcase
      end
      default: step = {1'b1, mpc_pkg::D_RUN, 16'h0000};
    endcase
  endfunction

  wire [24:0] cur = step(job, idx, period, off, cp_per, tp[0], tp[1], tp[2],
                         nt[0], nt[1], nt[2], flag_direction_select);
  wire cur_last = cur[24];

  wire [2:0] sw_idx = sw_addr[4:2] - 3'h3;
  wire [2:0] nw_idx = sw_addr[4:2] - 3'h6;
  wire       wr_tp  = sw_we && (sw_addr >= mpc_pkg::SW_TP) && (sw_addr < mpc_pkg::SW_NTP);
  wire       wr_nt  = sw_we && (sw_addr >= mpc_pkg::SW_NTP) && (sw_addr < mpc_pkg::SW_QSTEP);

  wire [31:0] rd_mux =
    (sw_addr == mpc_pkg::SW_STATUS) ? {25'h0, qleft != 15'h0, err, st} :
    (sw_addr == mpc_pkg::SW_PERIOD) ? {16'h0, period} :
    (sw_addr == mpc_pkg::SW_OFFSET) ? {16'h0, off} :
    wr_tp | (sw_addr >= mpc_pkg::SW_TP && sw_addr < mpc_pkg::SW_NTP) ? {16'h0, tp[sw_idx[1:0]]} :
    (sw_addr >= mpc_pkg::SW_NTP && sw_addr < mpc_pkg::SW_QSTEP) ? {16'h0, nt[nw_idx[1:0]]} :
    32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // sequencer
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st <= mpc_pkg::S_IDLE;
      job <= mpc_pkg::J_STOP;
      rjob <= mpc_pkg::J_STOP;
      idx <= 4'h0;
      dev_we <= 1'b0;
      dev_addr <= 8'h00;
      dev_wdata <= 16'h0000;
    end else begin
      dev_we <= 1'b0;
      case (st)
        mpc_pkg::S_SEQ: begin
          dev_we <= 1'b1;
          dev_addr <= cur[23:16];
          dev_wdata <= cur[15:0];
          idx <= cur_last ? 4'h0 : idx + 4'h1;
          if (cur_last) begin
            st <= (job == mpc_pkg::J_STOP) ? mpc_pkg::S_IDLE : mpc_pkg::S_RUN;
          end
          if (cur_last && (job != mpc_pkg::J_BUF)) begin
            rjob <= job;
          end
        end
        mpc_pkg::S_UPD: begin
          // hold the request until a match in reset-sync, or in complementary until an event leaves every value on its side
          if (upd_ok) begin
            st <= mpc_pkg::S_SEQ;
            job <= mpc_pkg::J_BUF;
          end
        end
        default: begin
          if (bad_cmd) begin
            st <= st;
          end else if (go_stop || go_rs || go_cp || go_ph) begin
            st <= mpc_pkg::S_SEQ;
            idx <= 4'h0;
            job <= go_stop ? mpc_pkg::J_STOP : go_rs ? mpc_pkg::J_RS
                 : go_cp ? mpc_pkg::J_CP : mpc_pkg::J_PH;
          end else if (go_upd) begin
            st <= mpc_pkg::S_UPD;
          end
        end
      endcase
    end
  end

  // software registers and status
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      period <= 16'h0000;
      off <= 16'h0000;
      flag_direction_select <= 1'b0;
      err <= 1'b0;
      dirm <= 3'b000;
      sw_rdata <= 32'h0000_0000;
      for (int k = 0; k < 3; k++) begin
        tp[k] <= 16'h0000;
        nt[k] <= 16'h0000;
      end
    end else begin
      sw_rdata <= sw_re ? rd_mux : 32'h0000_0000;
      if (wr_per && can_cmd) begin
        period <= sw_wdata[15:0];
      end else if (wr_off && can_cmd) begin
        off <= sw_wdata[15:0];
      end else if (wr_tp && can_cmd) begin
        tp[sw_idx[1:0]] <= sw_wdata[15:0];
      end else if (wr_nt && (st != mpc_pkg::S_UPD)) begin
        nt[nw_idx[1:0]] <= sw_wdata[15:0];
      end
      if (wr_ctrl) begin
        flag_direction_select <= sw_wdata[mpc_pkg::C_FLAG_DIRECTION_SELECT];
      end
      // a refused command on the clearing write still sets the flag
      if (bad_cmd) begin
        err <= 1'b1;
      end else if (wr_ctrl && sw_wdata[mpc_pkg::C_ECLR]) begin
        err <= 1'b0;
      end
      if ((st == mpc_pkg::S_UPD) && upd_ok) begin
        for (int k = 0; k < 3; k++) begin
          tp[k] <= nt[k];
          if (out_new[k] && (tp[k] <= cp_per)) begin
            dirm[k] <= ev_match;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event synchronisers and quadrature source
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      m_s <= 3'b000;
      u_s <= 3'b000;
    end else begin
      m_s <= {m_s[1:0], dev_match_a3};
      u_s <= {u_s[1:0], dev_udf4};
    end
  end

  wire [1:0] q_next = qdir ? qph - 2'h1 : qph + 2'h1;
  wire       q_step = (qgap == 2'h0) && (qleft != 15'h0);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      qleft <= 15'h0000;
      qdir <= 1'b0;
      qgap <= 2'h0;
      qph <= 2'h0;
      phase_input_a <= 1'b0;
      phase_input_b <= 1'b0;
    end else if (wr_qstep) begin
      qleft <= sw_wdata[14:0];
      qdir <= sw_wdata[mpc_pkg::Q_DIR];
    end else if (qgap != 2'h0) begin
      qgap <= qgap - 2'h1;
    end else if (q_step) begin
      qph <= q_next;
      phase_input_a <= q_next[1];
      phase_input_b <= q_next[1] ^ q_next[0];
      qleft <= qleft - 15'h0001;
      qgap <= 2'(mpc_pkg::Q_GAP - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  run_off_first_a: assert property (
    (st == mpc_pkg::S_SEQ && idx == 4'h0 && (job == mpc_pkg::J_RS || job == mpc_pkg::J_CP))
    |=> dev_we && dev_addr == mpc_pkg::D_RUN && dev_wdata == 16'h0000)
    else $error("setup did not halt counters first");
  start_last_a: assert property (
    (dev_we && dev_addr == mpc_pkg::D_RUN && dev_wdata != 16'h0000)
    |-> $past(st) == mpc_pkg::S_SEQ && st == mpc_pkg::S_RUN)
    else $error("counter started before setup finished");
  rs_tp_range_a: assert property (
    (dev_we && rjob != mpc_pkg::J_CP && job == mpc_pkg::J_RS && dev_addr == mpc_pkg::D_TURN_POINT_ONE)
    |-> dev_wdata <= period)
    else $error("turning point above period");
  cp_noclear_a: assert property (
    (dev_we && job == mpc_pkg::J_CP && dev_addr == mpc_pkg::D_TCR3)
    |-> dev_wdata == mpc_pkg::CLR_NONE ##1 dev_addr == mpc_pkg::D_TCR4)
    else $error("clear source selected in complementary setup");
  cp_offset_a: assert property (
    (dev_we && job == mpc_pkg::J_CP && dev_addr == mpc_pkg::D_CNT3)
    |-> dev_wdata != 16'h0000 && $past(dev_addr) == mpc_pkg::D_CNT4)
    else $error("offset zero or lag counter not cleared");
  cp_period_a: assert property (
    (dev_we && job == mpc_pkg::J_CP && dev_addr == mpc_pkg::D_PERIOD_COMPARE)
    |-> dev_wdata == {1'b0, period[15:1]} + off - 16'h0002)
    else $error("wrong complementary period");
  cp_tp_low_a: assert property (
    (dev_we && job == mpc_pkg::J_CP && dev_addr == mpc_pkg::D_TURN_POINT_ONE)
    |-> dev_wdata >= off)
    else $error("turning point below offset");
  buf_on_event_a: assert property (
    (st == mpc_pkg::S_UPD ##1 st == mpc_pkg::S_SEQ)
    |-> $past(ev_any))
    else $error("buffer write not timed on event");
  ph_order_a: assert property (
    (dev_we && dev_addr == mpc_pkg::D_RUN && dev_wdata == mpc_pkg::RUN2)
    |-> $past(dev_we) && $past(dev_addr) == mpc_pkg::D_TIMER_MODE_REG)
    else $error("phase run before mode set");
  quad_gap_a: assert property (
    ($changed(phase_input_a) || $changed(phase_input_b))
    |-> !($changed(phase_input_a) && $changed(phase_input_b))
        ##1 ($stable(phase_input_a) && $stable(phase_input_b)) [*2])
    else $error("phase edges too close");

  rs_start_c: cover property (st == mpc_pkg::S_SEQ && job == mpc_pkg::J_RS && cur_last);
  cp_start_c: cover property (st == mpc_pkg::S_SEQ && job == mpc_pkg::J_CP && cur_last);
  ph_start_c: cover property (st == mpc_pkg::S_SEQ && job == mpc_pkg::J_PH && cur_last);
  buf_upd_c: cover property (st == mpc_pkg::S_UPD ##1 st == mpc_pkg::S_SEQ);
  quad_c: cover property (q_step && qdir);
endmodule
`default_nettype wire

// *** core/mpc_pkg.sv ***
// constants for the motor pwm and phase counter host controller
// Behaviour
// - stop lead_counter with run_bit_three before selecting reset-synchronized pwm
// - reset-sync: load period, turning points not above it, clear source, zero counter
// - complementary: halt both counters, same clock, no clear source
// - complementary: lag_counter zero, lead_counter gets nonzero non-overlap offset
// - complementary: period_compare is half cycle plus offset minus two
// - complementary: initial turning points at least the lead_counter start value
// - no turning point below the offset before the first period match
// - change turning points during complementary pwm only through shadow registers
// - at up-to-down turn, never buffer across the band near period_compare
// - at down-to-up turn, never buffer across the band below the offset
// - out-of-range and return writes in same direction, timed on device events
// - phase counting: set phase_mode_bit and flag direction, then run bit two
// - every phase edge counts; keep 1.5 cycle spacing, 2.5 cycle pulse width
package mpc_pkg;
  localparam int unsigned CLK_NS = 100;
  // software register offsets
  localparam logic [7:0] SW_CTRL   = 8'h00;
  localparam logic [7:0] SW_PERIOD = 8'h04;
  localparam logic [7:0] SW_OFFSET = 8'h08;
  localparam logic [7:0] SW_TP     = 8'h0c;
  localparam logic [7:0] SW_NTP    = 8'h18;
  localparam logic [7:0] SW_QSTEP  = 8'h24;
  localparam logic [7:0] SW_STATUS = 8'h28;
  // control bits
  localparam int unsigned C_RS = 0;
  localparam int unsigned C_CP = 1;
  localparam int unsigned C_PH = 2;
  localparam int unsigned C_UPD = 3;
  localparam int unsigned C_STOP = 4;
  localparam int unsigned C_FLAG_DIRECTION_SELECT = 5;
  localparam int unsigned C_ECLR = 6;
  localparam int unsigned Q_DIR = 16;
  // device register offsets
  localparam logic [7:0] D_RUN  = 8'h00;
  localparam logic [7:0] D_TCR3 = 8'h01;
  localparam logic [7:0] D_TCR4 = 8'h02;
  localparam logic [7:0] D_FUNC = 8'h03;
  localparam logic [7:0] D_CNT3 = 8'h04;
  localparam logic [7:0] D_CNT4 = 8'h05;
  localparam logic [7:0] D_PERIOD_COMPARE = 8'h06;
  localparam logic [7:0] D_TURN_POINT_ONE = 8'h07;
  localparam logic [7:0] D_TURN_POINT_TWO = 8'h08;
  localparam logic [7:0] D_TURN_POINT_THREE = 8'h09;
  localparam logic [7:0] D_BRB3 = 8'h0a;
  localparam logic [7:0] D_BRA4 = 8'h0b;
  localparam logic [7:0] D_BRB4 = 8'h0c;
  localparam logic [7:0] D_TIMER_MODE_REG = 8'h0d;
  // device field values
  localparam logic [15:0] RUN2 = 16'h0004;
  localparam logic [15:0] RUN3 = 16'h0008;
  localparam logic [15:0] RUN4 = 16'h0010;
  localparam logic [15:0] CLR_NONE = 16'h0000;
  localparam logic [15:0] CLR_PERIOD_COMPARE = 16'h0020;
  localparam logic [15:0] MODE_RS = 16'h0003;
  localparam logic [15:0] MODE_CP = 16'h0002;
  localparam logic [15:0] BUF_ALL = 16'h0038;
  localparam logic [15:0] PHASE_BIT = 16'h0040;
  localparam logic [15:0] FLAG_DIRECTION_SELECT_BIT = 16'h0080;
  // least spacing of phase edges
  localparam int unsigned Q_GAP_NS = 300;
  localparam int unsigned Q_GAP = (Q_GAP_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_SEQ  = 5'b00010,
    S_RUN  = 5'b00100,
    S_UPD  = 5'b01000,
    S_ERR  = 5'b10000
  } mpc_state_t;
  typedef enum logic [4:0] {
    J_RS   = 5'b00001,
    J_CP   = 5'b00010,
    J_PH   = 5'b00100,
    J_BUF  = 5'b01000,
    J_STOP = 5'b10000
  } mpc_job_t;
endpackage

// *** test/motor_pwm_and_phase_counter_bench.sv ***
// self-checking bench: host controller against the device model
`timescale 1ns/100ps
`default_nettype none
`define MPC_CMP(nm, e, s) begin n_compared++; if ((s) !== (e)) begin fail_count++; $display("BAD %s expected %h seen %h", nm, e, s); end end
module motor_pwm_and_phase_counter_bench;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_we = 1'b0;
  logic        sw_re = 1'b0;
  logic        re_d = 1'b0;
  logic [31:0] sw_rdata;
  logic [7:0]  dev_addr;
  logic [15:0] dev_wdata;
  logic        dev_we, m3, u4, pa, pb;
  logic [15:0] q_count;
  logic [7:0]  gap_bad;
  logic [31:0] lfsr = 32'd70621;
  logic [31:0] er;
  logic [23:0] ew;
  logic [31:0] rd_q [$];
  logic [23:0] wr_q [$];
  int          fail_count = 0;
  int          n_compared = 0;
  always #50 clock = ~clock;
  mpc_host mpc_host_inst (.clock(clock), .rst_n(rst_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_we(sw_we), .sw_re(sw_re), .sw_rdata(sw_rdata), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_we(dev_we), .dev_match_a3(m3), .dev_udf4(u4), .phase_input_a(pa), .phase_input_b(pb));
  mpc_dev_model mpc_dev_model_inst (.clock(clock), .rst_n(rst_n), .dev_addr(dev_addr),
    .dev_wdata(dev_wdata), .dev_we(dev_we), .phase_input_a(pa), .phase_input_b(pb),
    .dev_match_a3(m3), .dev_udf4(u4), .q_count(q_count), .phase_pins(), .gap_bad(gap_bad));
  ////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    re_d <= sw_re;
    if (re_d) begin
      er = rd_q.size() ? rd_q.pop_front() : 'x;
      `MPC_CMP("sw_rdata", er, sw_rdata)
    end
    if (dev_we === 1'b1) begin
      ew = wr_q.size() ? wr_q.pop_front() : 'x;
      `MPC_CMP("dev_write", ew, {dev_addr, dev_wdata})
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [31:0] nx();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0);
    return lfsr;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    sw_addr <= a;
    sw_wdata <= d;
    sw_we <= 1'b1;
    @(posedge clock);
    sw_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clock);
    sw_addr <= a;
    sw_re <= 1'b1;
    @(posedge clock);
    sw_re <= 1'b0;
  endtask
  task automatic ex(input logic [7:0] a, input logic [15:0] d);
    wr_q.push_back({a, d});
  endtask
  // bounded wait for all noted device writes to appear
  task automatic drain(input int lim);
    for (int i = 0; i < lim && wr_q.size() != 0; i++) @(posedge clock);
    if (wr_q.size() != 0) begin
      fail_count++;
      complete_run();
    end
  endtask
  task automatic exp_tp(input logic [15:0] t [3], input logic gr, input logic [15:0] run);
    for (int k = 0; k < 3; k++) if (gr) ex(8'(mpc_pkg::D_TURN_POINT_ONE + k), t[k]);
    for (int k = 0; k < 3; k++) ex(8'(mpc_pkg::D_BRB3 + k), t[k]);
    // a buffer update ends on the last shadow write, with no run write
    if (gr) ex(mpc_pkg::D_RUN, run);
  endtask
  task automatic load(input logic [15:0] p, input logic [15:0] o, input logic [15:0] t [3]);
    wr(mpc_pkg::SW_PERIOD, 32'(p));
    wr(mpc_pkg::SW_OFFSET, 32'(o));
    for (int k = 0; k < 3; k++) wr(8'(mpc_pkg::SW_TP + 4 * k), 32'(t[k]));
  endtask
  task automatic stop();
    ex(mpc_pkg::D_RUN, 16'h0000);
    wr(mpc_pkg::SW_CTRL, 32'h10);
    drain(20);
    rd(mpc_pkg::SW_STATUS, 32'h01);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] per, off, gra, lim;
    logic [15:0] tp [3];
    int n;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rd(mpc_pkg::SW_STATUS, 32'h01);
    rd(8'h40, 32'h0);
    per = 16'd20 + 16'(nx() % 16);
    for (int k = 0; k < 3; k++) tp[k] = 16'(nx() % (per + 1));
    tp[2] = per;
    load(per, 16'h0, tp);
    ex(8'h00, 16'h0000); ex(8'h01, 16'h0020); ex(8'h03, 16'h003b); ex(8'h04, 16'h0000);
    ex(mpc_pkg::D_PERIOD_COMPARE, per);
    exp_tp(tp, 1'b1, mpc_pkg::RUN3);
    wr(mpc_pkg::SW_CTRL, 32'h01);
    drain(40);
    rd(mpc_pkg::SW_STATUS, 32'h04);
    for (int k = 0; k < 3; k++) wr(8'(mpc_pkg::SW_NTP + 4 * k), 32'(k));
    tp = '{16'h0, 16'h1, 16'h2};
    exp_tp(tp, 1'b0, mpc_pkg::RUN3);
    wr(mpc_pkg::SW_CTRL, 32'h08);
    drain(150);
    stop();
    wr(mpc_pkg::SW_TP, 32'(per + 16'h1));
    wr(mpc_pkg::SW_CTRL, 32'h01);
    rd(mpc_pkg::SW_STATUS, 32'h21);
    wr(mpc_pkg::SW_CTRL, 32'h40);
    rd(mpc_pkg::SW_STATUS, 32'h01);
    wr(mpc_pkg::SW_CTRL, 32'h02);
    rd(mpc_pkg::SW_STATUS, 32'h21);
    off = 16'd3 + 16'(nx() % 4);
    per = 16'd40 + 16'(nx() % 16);
    gra = per / 2 + off - 16'd2;
    lim = per / 2 - 16'd2 - off;
    for (int k = 0; k < 3; k++) tp[k] = off + 16'(nx() % (lim + 1));
    load(per, off, tp);
    wr(mpc_pkg::SW_TP, 32'(off - 16'h1));
    wr(mpc_pkg::SW_CTRL, 32'h42);
    rd(mpc_pkg::SW_STATUS, 32'h21);
    wr(mpc_pkg::SW_CTRL, 32'h40);
    wr(mpc_pkg::SW_TP, 32'(tp[0]));
    ex(8'h00, 16'h0000); ex(8'h01, 16'h0000); ex(8'h02, 16'h0000); ex(8'h03, 16'h003a);
    ex(8'h05, 16'h0000); ex(8'h04, off); ex(mpc_pkg::D_PERIOD_COMPARE, gra);
    exp_tp(tp, 1'b1, mpc_pkg::RUN3 | mpc_pkg::RUN4);
    wr(mpc_pkg::SW_CTRL, 32'h02);
    drain(40);
    rd(mpc_pkg::SW_STATUS, 32'h04);
    for (int k = 0; k < 3; k++) tp[k] = off + 16'(nx() % (lim + 1));
    for (int k = 0; k < 3; k++) wr(8'(mpc_pkg::SW_NTP + 4 * k), 32'(tp[k]));
    exp_tp(tp, 1'b0, mpc_pkg::RUN3 | mpc_pkg::RUN4);
    wr(mpc_pkg::SW_CTRL, 32'h08);
    drain(300);
    stop();
    ex(mpc_pkg::D_TIMER_MODE_REG, mpc_pkg::PHASE_BIT | mpc_pkg::FLAG_DIRECTION_SELECT_BIT);
    ex(mpc_pkg::D_RUN, mpc_pkg::RUN2);
    wr(mpc_pkg::SW_CTRL, 32'h24);
    drain(20);
    n = 5 + int'(nx() % 20);
    wr(mpc_pkg::SW_QSTEP, 32'(n));
    rd(mpc_pkg::SW_STATUS, 32'h44);
    repeat (3 * n + 12) @(posedge clock);
    `MPC_CMP("q_count", 16'(n), q_count)
    wr(mpc_pkg::SW_QSTEP, 32'h0001_0000 | 32'(n + 3));
    repeat (3 * n + 21) @(posedge clock);
    `MPC_CMP("q_count", 16'hfffd, q_count)
    `MPC_CMP("gap_bad", 8'h00, gap_bad)
    repeat (4) @(posedge clock);
    complete_run();
  end
endmodule
`default_nettype wire

// *** test/mpc_dev_model.sv ***
// behavioural model of timer channels two to four seen by the host
`timescale 1ns/100ps
`default_nettype none
module mpc_dev_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic [7:0]  dev_addr,
  input  wire logic [15:0] dev_wdata,
  input  wire logic        dev_we,
  input  wire logic        phase_input_a,
  input  wire logic        phase_input_b,
  output logic             dev_match_a3,
  output logic             dev_udf4,
  output logic [15:0]      q_count,
  output logic [5:0]       phase_pins,
  output logic [7:0]       gap_bad
);
  logic [15:0] rg [14];
  logic [15:0] c3;
  logic [15:0] c4;
  logic        down;
  logic        pa;
  logic        pb;
  logic [3:0]  gap;
  wire logic rs   = rg[3][1:0] == 2'h3;
  wire logic cp   = rg[3][1:0] == 2'h2;
  wire logic run3 = rg[0][3];
  wire logic run4 = rg[0][4];
  // match only on the increment side, underflow only going down
  wire logic mat  = run3 & (rs | (cp & run4 & ~down)) & (c3 == rg[6]);
  wire logic udf  = cp & run3 & run4 & down & (c4 == 16'h0000);
  wire logic dn   = mat | (down & ~udf);
  wire logic ea   = phase_input_a ^ pa;
  wire logic eb   = phase_input_b ^ pb;
  wire logic inc  = eb ? (phase_input_a ^ phase_input_b) : (phase_input_a ~^ phase_input_b);
  assign dev_match_a3 = mat;
  assign dev_udf4     = udf;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      for (int i = 0; i < 14; i++) rg[i] <= 16'h0000;
      c3 <= 16'h0000;
      c4 <= 16'h0000;
      down <= 1'b0;
      q_count <= 16'h0000;
      pa <= 1'b0;
      pb <= 1'b0;
      gap <= 4'hf;
      gap_bad <= 8'h00;
    end else begin
      pa <= phase_input_a;
      pb <= phase_input_b;
      if (dev_we && dev_addr < 8'h0e) rg[dev_addr[3:0]] <= dev_wdata;
      // buffered turning points follow the counter events
      for (int k = 0; k < 3; k++) begin
        if ((mat | udf) && rg[3][3+k]) rg[7+k] <= rg[10+k];
      end
      if (dev_we && dev_addr == 8'h04) c3 <= dev_wdata;
      else if (dev_we && dev_addr == 8'h05) c4 <= dev_wdata;
      else if (rs && run3) c3 <= mat ? 16'h0000 : c3 + 16'h0001;
      else if (cp && run3 && run4) begin
        c3 <= dn ? c3 - 16'h0001 : c3 + 16'h0001;
        c4 <= dn ? c4 - 16'h0001 : c4 + 16'h0001;
        down <= dn;
      end
      // every edge of both inputs counts; wrap is plain modulo
      if ((ea | eb) && rg[13][6] && rg[0][2]) q_count <= inc ? q_count + 16'h0001 : q_count - 16'h0001;
      if (ea | eb) begin
        gap <= 4'h0;
        if (gap < 4'h2 || (ea & eb)) gap_bad <= gap_bad + 8'h01;
      end else if (gap != 4'hf) gap <= gap + 4'h1;
    end
  end
  ////////////////////////////////////////////////////////////
  // lag counter drives the positive side in complementary mode, lead counter in reset-sync, so pairs never overlap
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      phase_pins[2*k]   = rs ? (c3 >= rg[7+k]) : cp & (c4 >= rg[7+k]);
      phase_pins[2*k+1] = rs ? (c3 < rg[7+k]) : cp & (c3 < rg[7+k]);
    end
  end
endmodule
`default_nettype wire
